// [src/rcec_pkg.sv]
// package for the remote command error checker: codes, categories, carriers
// assumes a single 20 MHz clock domain, no software-reachable registers
//
// Behaviour
// - unmatched command header, bad characters or keywords log -101
// - space beside colon makes the header unmatched (-101, or -201 in a query); missing space before parameters counts as -101
// - numeric argument must be sign, digits, one point, optional exponent, else -102
// - enable-mask argument outside 0..255 is rejected as invalid argument
// - boolean parameter other than single 0 or 1 logs -103
// - termination before a required argument logs -104, command not executed
// - parameter outside its permitted range logs -105
// - writing zero offset or span in percent units logs -106
// - calibration change with missing or wrong passcode refused, logs -107
// - selecting user calibration when none exists refused, logs -108
// - unmatched query ending in question mark logs -201
// - new query during pending response discards remainder, logs -202
// - reading zero offset or span in percent units logs -203
// - four input buffers full drops new command and logs -301
// - over ten pending errors logs -302, then records none until one read
// - nonvolatile checksum mismatch logs -401
// - serial framing error logs -402
// - serial parity mismatch logs -403
// - serial receive overrun logs -404
// - queue of ten entries, read oldest first, removed on read
// - each error is a negative three-digit code with text description
// - reading an empty queue returns code zero, no errors
// - each category sets its own sticky event bit until user clears it
package rcec_pkg;
	localparam int RCEC_QDEPTH = 10;
	localparam int RCEC_QIDXW = 4;
	localparam int RCEC_NSRC = 19;
	localparam int RCEC_NINBUF = 4;
	localparam logic [7:0] RCEC_MASK_MAX = 8'hff;

	// codes held as their magnitude, shown negative to the host
	localparam logic [9:0] RCEC_E_NONE = 10'h000;
	localparam logic [9:0] RCEC_E_UNRCMD = 10'h065;
	localparam logic [9:0] RCEC_E_BADARG = 10'h066;
	localparam logic [9:0] RCEC_E_NONBOOL = 10'h067;
	localparam logic [9:0] RCEC_E_MISSPAR = 10'h068;
	localparam logic [9:0] RCEC_E_RANGE = 10'h069;
	localparam logic [9:0] RCEC_E_LENSET = 10'h06a;
	localparam logic [9:0] RCEC_E_PASSCODE = 10'h06b;
	localparam logic [9:0] RCEC_E_NOUCAL = 10'h06c;
	localparam logic [9:0] RCEC_E_UNRQRY = 10'h0c9;
	localparam logic [9:0] RCEC_E_QINTR = 10'h0ca;
	localparam logic [9:0] RCEC_E_LENQRY = 10'h0cb;
	localparam logic [9:0] RCEC_E_INOVF = 10'h12d;
	localparam logic [9:0] RCEC_E_ERROVF = 10'h12e;
	localparam logic [9:0] RCEC_E_CKSUM = 10'h191;
	localparam logic [9:0] RCEC_E_FRAME = 10'h192;
	localparam logic [9:0] RCEC_E_PARITY = 10'h193;
	localparam logic [9:0] RCEC_E_OVERRUN = 10'h194;

	typedef enum logic [1:0] {
		RCEC_CAT_CMD = 2'h0,
		RCEC_CAT_QRY = 2'h1,
		RCEC_CAT_EXE = 2'h3,
		RCEC_CAT_DEV = 2'h2
	} rcec_cat_t;

	// remote units
	localparam logic [1:0] RCEC_UNIT_PCT = 2'h0;

	// classified command as delivered by the parser, one-cycle valid
	typedef struct packed {
		logic valid;
		logic is_query;
		logic hdr_ok;
		logic colon_space;
		logic no_param_space;
		logic num_arg;
		logic num_ok;
		logic mask_arg;
		logic [8:0] mask_val;
		logic bool_arg;
		logic bool_ok;
		logic need_arg;
		logic arg_seen;
		logic range_bad;
		logic len_access;
		logic cal_change;
		logic pass_given;
		logic pass_match;
		logic sel_user;
	} rcec_cmd_t;

	// serial receiver and system events, one-cycle pulses
	typedef struct packed {
		logic frame_err;
		logic parity_err;
		logic overrun;
		logic cksum_bad;
		logic new_cmd;
	} rcec_evt_t;

	typedef struct packed {
		logic valid;
		logic [9:0] code;
		rcec_cat_t cat;
	} rcec_err_t;
endpackage

// [src/rcec_errq.sv]
// ten-entry error queue with overflow marker
// assumes one error pushed per cycle at most; pop from the status reader
`timescale 1ns/1ps
`default_nettype none
module rcec_errq import rcec_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// push side
	input wire logic push,
	input wire logic [9:0] push_code,
	// pop side
	input wire logic pop,
	output logic [9:0] head_code,
	output logic [RCEC_QIDXW-1:0] count
);
	logic [9:0] mem [RCEC_QDEPTH];
	logic [RCEC_QIDXW-1:0] rd_ptr;
	logic [RCEC_QIDXW-1:0] wr_ptr;
	logic locked;

	////////////////////////////////////////////////////////////////////////
	// decode
	wire q_empty = (count == '0);
	wire q_full = (count == RCEC_QIDXW'(RCEC_QDEPTH));
	wire do_pop = pop && !q_empty;
	// a push to a full queue overwrites the newest entry once, then locks
	wire do_push = push && !q_full && !locked;
	wire do_ovf = push && q_full && !locked;
	wire [RCEC_QIDXW-1:0] last_idx = (wr_ptr == '0) ?
		RCEC_QIDXW'(RCEC_QDEPTH - 1) : wr_ptr - 1'b1;
	wire [RCEC_QIDXW-1:0] next_wr = (wr_ptr == RCEC_QIDXW'(RCEC_QDEPTH - 1))
		? '0 : wr_ptr + 1'b1;
	wire [RCEC_QIDXW-1:0] next_rd = (rd_ptr == RCEC_QIDXW'(RCEC_QDEPTH - 1))
		? '0 : rd_ptr + 1'b1;
	assign head_code = q_empty ? RCEC_E_NONE : mem[rd_ptr];

	// storage, indexed writes
	always_ff @(posedge sys_clk) begin
		if (do_push)
			mem[wr_ptr] <= push_code;
		else if (do_ovf)
			mem[last_idx] <= RCEC_E_ERROVF;
	end

	// pointers and count: oldest first, removed on read
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
			locked <= 1'b0;
		end else begin
			if (do_push)
				wr_ptr <= next_wr;
			if (do_pop)
				rd_ptr <= next_rd;
			count <= count + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
			// lock lifts once the host has read an entry
			if (do_pop)
				locked <= 1'b0;
			else if (do_ovf)
				locked <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [src/rcec_inbuf.sv]
// occupancy tracker for the four pending input command buffers
// assumes new_cmd from the receiver and done from the interpreter
`timescale 1ns/1ps
`default_nettype none
module rcec_inbuf import rcec_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// events
	input wire logic arrive,
	input wire logic done,
	output logic accept,
	output logic drop,
	output logic [2:0] used
);
	wire full = (used == 3'(RCEC_NINBUF));
	wire take = arrive && !full;
	wire freed = done && (used != '0);
	assign accept = take;
	assign drop = arrive && full;

	// occupancy counter; drop leaves the buffers untouched
	always_ff @(posedge sys_clk) begin
		if (srst)
			used <= '0;
		else
			used <= used + (take ? 3'h1 : 3'h0) - (freed ? 3'h1 : 3'h0);
	end
endmodule
`default_nettype wire

// [src/rcec_top.sv]
// remote command error checker: classifies parsed commands, serial events
// and system faults into numbered errors, queues them, flags categories
// assumes parser delivers one classified command per valid pulse; serial
// events arrive as pins from another domain and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module rcec_top import rcec_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// parsed command from the interpreter
	input wire rcec_cmd_t cmd,
	input wire logic [1:0] units,
	input wire logic ucal_exists,
	input wire logic resp_busy,
	input wire logic cmd_done,
	// asynchronous serial fault toggles and checksum level, synchronised here; new_cmd is used directly
	input wire logic frame_tgl,
	input wire logic parity_tgl,
	input wire logic overrun_tgl,
	input wire logic cksum_bad,
	input wire logic new_cmd,
	// error queue readout
	input wire logic err_read,
	input wire logic [3:0] cat_clear,
	output logic [9:0] err_code,
	output logic err_empty,
	output logic [3:0] err_count,
	// status outputs
	output logic [3:0] cat_flags,
	output rcec_err_t err_strobe,
	output logic cmd_exec,
	output logic resp_flush,
	output logic cmd_drop,
	output logic [2:0] inbuf_used
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: toggles cross as levels, edges found after stage 2
	logic [2:0] tg_s1;
	logic [2:0] tg_s2;
	logic [2:0] tg_s3;
	logic ck_s1;
	logic ck_s2;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tg_s1 <= '0;
			tg_s2 <= '0;
			tg_s3 <= '0;
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
		end else begin
			tg_s1 <= {overrun_tgl, parity_tgl, frame_tgl};
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
			ck_s1 <= cksum_bad;
			ck_s2 <= ck_s1;
		end
	end
	wire [2:0] ser_ev = tg_s2 ^ tg_s3;

	// checksum fault is a level; report it on its rising edge only
	logic ck_prev;
	always_ff @(posedge sys_clk) begin
		if (srst)
			ck_prev <= 1'b0;
		else
			ck_prev <= ck_s2;
	end
	wire ck_ev = ck_s2 && !ck_prev;

	////////////////////////////////////////////////////////////////////////
	// input buffer occupancy
	logic ib_drop;
	logic [2:0] ib_used;
	rcec_inbuf u_inbuf (
		.sys_clk(sys_clk),
		.srst(srst),
		.arrive(new_cmd),
		.done(cmd_done),
		.accept(),
		.drop(ib_drop),
		.used(ib_used)
	);

	////////////////////////////////////////////////////////////////////////
	// command classification, checked in order of precedence
	wire c_v = cmd.valid;
	wire c_q = cmd.is_query;
	wire pct = (units == RCEC_UNIT_PCT);
	// bad spacing around colons makes the header unrecognisable
	wire c_space = cmd.colon_space || (!c_q && cmd.no_param_space);
	wire c_hdr_bad = !cmd.hdr_ok || c_space;
	wire e_unrcmd = c_v && !c_q && c_hdr_bad;
	wire e_unrqry = c_v && c_q && c_hdr_bad;
	wire e_lenqry = c_v && c_q && !c_hdr_bad && cmd.len_access && pct;
	wire e_qintr = c_v && c_q && !c_hdr_bad && resp_busy;
	wire c_ok = c_v && !c_q && !c_hdr_bad;
	wire e_miss = c_ok && cmd.need_arg && !cmd.arg_seen;
	wire c_arg = c_ok && !e_miss;
	wire mask_bad = cmd.mask_arg && (cmd.mask_val > {1'b0, RCEC_MASK_MAX});
	wire e_badarg = c_arg && ((cmd.num_arg && !cmd.num_ok) || mask_bad);
	wire e_nonbool = c_arg && cmd.bool_arg && !cmd.bool_ok;
	wire c_fmt = c_arg && !e_badarg && !e_nonbool;
	wire e_pass = c_fmt && cmd.cal_change &&
		(!cmd.pass_given || !cmd.pass_match);
	wire e_noucal = c_fmt && !e_pass && cmd.sel_user && !ucal_exists;
	wire e_lenset = c_fmt && cmd.len_access && pct;
	wire e_range = c_fmt && !e_lenset && cmd.range_bad;
	wire c_err = e_unrcmd || e_miss || e_badarg || e_nonbool || e_pass ||
		e_noucal || e_lenset || e_range;

	////////////////////////////////////////////////////////////////////////
	// error sources as a vector, lowest index wins within a cycle
	logic [RCEC_NSRC-1:0] src;
	logic [9:0] src_code [RCEC_NSRC];
	assign src = {ck_ev, ser_ev[2], ser_ev[1], ser_ev[0], ib_drop,
		e_lenqry, e_qintr, e_unrqry, e_range, e_lenset, e_noucal, e_pass,
		e_range & 1'b0, e_nonbool, e_badarg, e_miss, e_unrcmd, 1'b0, 1'b0};
	assign src_code[0] = RCEC_E_NONE;
	assign src_code[1] = RCEC_E_NONE;
	assign src_code[2] = RCEC_E_UNRCMD;
	assign src_code[3] = RCEC_E_MISSPAR;
	assign src_code[4] = RCEC_E_BADARG;
	assign src_code[5] = RCEC_E_NONBOOL;
	assign src_code[6] = RCEC_E_NONE;
	assign src_code[7] = RCEC_E_PASSCODE;
	assign src_code[8] = RCEC_E_NOUCAL;
	assign src_code[9] = RCEC_E_LENSET;
	assign src_code[10] = RCEC_E_RANGE;
	assign src_code[11] = RCEC_E_UNRQRY;
	assign src_code[12] = RCEC_E_QINTR;
	assign src_code[13] = RCEC_E_LENQRY;
	assign src_code[14] = RCEC_E_INOVF;
	assign src_code[15] = RCEC_E_FRAME;
	assign src_code[16] = RCEC_E_PARITY;
	assign src_code[17] = RCEC_E_OVERRUN;
	assign src_code[18] = RCEC_E_CKSUM;

	// events lost to a same-cycle winner wait in a pending set
	logic [RCEC_NSRC-1:0] pend;
	wire [RCEC_NSRC-1:0] all_src = pend | src;
	logic [RCEC_NSRC-1:0] sel_oh;
	logic [9:0] sel_code;
	always_comb begin
		sel_oh = '0;
		sel_code = RCEC_E_NONE;
		for (int i = RCEC_NSRC - 1; i >= 0; i--) begin
			if (all_src[i]) begin
				sel_oh = RCEC_NSRC'(1) << i;
				sel_code = src_code[i];
			end
		end
	end
	wire sel_any = |all_src;
	wire [RCEC_NSRC-1:0] next_pend = all_src & ~sel_oh;

	// category of the chosen code follows its hundreds digit
	wire [1:0] sel_cat = (sel_code >= RCEC_E_CKSUM) ? RCEC_CAT_DEV :
		(sel_code >= RCEC_E_INOVF) ? RCEC_CAT_EXE :
		(sel_code >= RCEC_E_UNRQRY) ? RCEC_CAT_QRY : RCEC_CAT_CMD;

	always_ff @(posedge sys_clk) begin
		if (srst)
			pend <= '0;
		else
			pend <= next_pend;
	end

	////////////////////////////////////////////////////////////////////////
	// error queue
	logic [9:0] q_head;
	logic [RCEC_QIDXW-1:0] q_count;
	rcec_errq u_errq (
		.sys_clk(sys_clk),
		.srst(srst),
		.push(sel_any),
		.push_code(sel_code),
		.pop(err_read),
		.head_code(q_head),
		.count(q_count)
	);

	////////////////////////////////////////////////////////////////////////
	// sticky category flags: a new event wins over a same-cycle clear
	logic [3:0] set_cat;
	always_comb begin
		set_cat = '0;
		if (sel_any)
			set_cat[sel_cat] = 1'b1;
	end
	wire [3:0] next_flags = (cat_flags & ~cat_clear) | set_cat;

	// registered outputs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cat_flags <= '0;
			err_strobe <= '0;
			cmd_exec <= 1'b0;
			resp_flush <= 1'b0;
			cmd_drop <= 1'b0;
			inbuf_used <= '0;
			err_code <= '0;
			err_empty <= 1'b1;
			err_count <= '0;
		end else begin
			cat_flags <= next_flags;
			// strobe fires even when the queue cannot store it
			err_strobe <= '{valid: sel_any, code: sel_code,
				cat: rcec_cat_t'(sel_cat)};
			// commands with any error are not executed
			cmd_exec <= c_ok && !c_err;
			// the new query replaces any unsent response
			resp_flush <= e_qintr;
			cmd_drop <= ib_drop;
			inbuf_used <= ib_used;
			err_code <= q_head;
			err_empty <= (q_count == '0);
			err_count <= q_count;
		end
	end
endmodule
`default_nettype wire

// [tb/rcec_checker.sv]
// assertions on the error checker top ports
// assumes a bind from the testbench top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module rcec_checker import rcec_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// stimulus side
	input wire rcec_cmd_t cmd,
	input wire logic resp_busy,
	input wire logic cmd_done,
	input wire logic new_cmd,
	input wire logic [3:0] cat_clear,
	// watched outputs
	input wire logic [9:0] err_code,
	input wire logic err_empty,
	input wire logic [3:0] err_count,
	input wire logic [3:0] cat_flags,
	input wire rcec_err_t err_strobe,
	input wire logic cmd_exec,
	input wire logic resp_flush,
	input wire logic cmd_drop,
	input wire logic [2:0] inbuf_used
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic [1:0] last_cat;
	logic prev_ok;
	// history for checks that look one cycle back
	always_ff @(posedge sys_clk) begin
		last_cat <= err_strobe.cat;
		prev_ok <= cmd.valid && !cmd.is_query && cmd.hdr_ok && cmd.arg_seen;
	end
	// category follows the hundreds digit of the code
	function automatic logic [1:0] cat_of(input logic [9:0] c);
		return c < 10'h0c8 ? 2'h0 : c < 10'h12c ? 2'h1 : c < 10'h190 ? 2'h3 : 2'h2;
	endfunction
	property p_unr;
		cmd.valid && !cmd.is_query && !cmd.hdr_ok |->
			##[1:20] err_strobe.valid && err_strobe.code == 10'h065;
	endproperty
	a_unr: assert property (p_unr) else $error("bad header not reported");
	property p_exec;
		cmd_exec |-> prev_ok;
	endproperty
	a_exec: assert property (p_exec) else $error("faulty command executed");
	property p_flush;
		cmd.valid && cmd.is_query && cmd.hdr_ok && !cmd.colon_space &&
			resp_busy |=> resp_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("no response flush");
	property p_drop;
		new_cmd && inbuf_used == 3'h4 && !cmd_done |=> cmd_drop;
	endproperty
	a_drop: assert property (p_drop) else $error("full buffers not dropped");
	property p_ovf;
		cmd_drop |-> ##[0:20] err_strobe.valid && err_strobe.code == 10'h12d;
	endproperty
	a_ovf: assert property (p_ovf) else $error("input overflow not logged");
	property p_cat;
		err_strobe.valid |-> err_strobe.code != 10'h000 &&
			err_strobe.cat == cat_of(err_strobe.code);
	endproperty
	a_cat: assert property (p_cat) else $error("strobe category wrong");
	property p_flag;
		err_strobe.valid && cat_clear == 4'h0 |=> cat_flags[last_cat];
	endproperty
	a_flag: assert property (p_flag) else $error("category flag not set");
	property p_sticky;
		($past(cat_flags) & ~cat_flags & ~$past(cat_clear)) == 4'h0;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag fell uncleared");
	property p_empty;
		err_empty |-> err_count == 4'h0 && err_code == 10'h000;
	endproperty
	a_empty: assert property (p_empty) else $error("empty queue not zero");
	property p_cnt;
		err_count <= 4'ha;
	endproperty
	a_cnt: assert property (p_cnt) else $error("queue above ten");
	c_flush: cover property (resp_flush);
	c_drop: cover property (cmd_drop);
	c_full: cover property (err_count == 4'ha);
endmodule
`default_nettype wire

// [tb/rcec_host.sv]
// host side model: serial receiver faults and memory checksum level
// assumes the testbench calls fault() from its main sequence
`timescale 1ns/1ps
`default_nettype none
module rcec_host (
	// clock
	input wire logic sys_clk,
	// fault pins toward the checker
	output logic frame_tgl,
	output logic parity_tgl,
	output logic overrun_tgl,
	output logic cksum_bad
);
	// pins stable at zero through reset, else a spurious event appears
	initial begin
		frame_tgl = 1'b0;
		parity_tgl = 1'b0;
		overrun_tgl = 1'b0;
		cksum_bad = 1'b0;
	end
	// one mismatched setting or fault, launched just after an edge
	task automatic fault(input int k);
		@(posedge sys_clk);
		#1;
		case (k)
			0: frame_tgl = ~frame_tgl;
			1: parity_tgl = ~parity_tgl;
			2: overrun_tgl = ~overrun_tgl;
			default: cksum_bad = 1'b1;
		endcase
	endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the remote command error checker
// assumes the design package is compiled first
`timescale 1ns/1ps
`default_nettype none
bind rcec_top rcec_checker chk_u (.sys_clk, .srst, .cmd, .resp_busy,
	.cmd_done, .new_cmd, .cat_clear, .err_code, .err_empty, .err_count,
	.cat_flags, .err_strobe, .cmd_exec, .resp_flush, .cmd_drop, .inbuf_used);
module testbench import rcec_pkg::*;;
	logic sys_clk, srst, ucal_exists, resp_busy, cmd_done, new_cmd, err_read;
	logic frame_tgl, parity_tgl, overrun_tgl, cksum_bad;
	logic err_empty, cmd_exec, resp_flush, cmd_drop;
	logic [1:0] units;
	logic [2:0] inbuf_used;
	logic [3:0] cat_clear, err_count, cat_flags;
	logic [9:0] err_code;
	rcec_cmd_t cmd, base;
	rcec_err_t err_strobe;
	int failures, checked;
	rcec_top dut_u (.sys_clk, .srst, .cmd, .units, .ucal_exists, .resp_busy,
		.cmd_done, .frame_tgl, .parity_tgl, .overrun_tgl, .cksum_bad,
		.new_cmd, .err_read, .cat_clear, .err_code, .err_empty, .err_count,
		.cat_flags, .err_strobe, .cmd_exec, .resp_flush, .cmd_drop,
		.inbuf_used);
	rcec_host host_u (.sys_clk, .frame_tgl, .parity_tgl, .overrun_tgl,
		.cksum_bad);
	////////////////////////////////////////
	// 50 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic end_sim();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// all tasks start and end just after an edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp,
		input string m);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic send(input rcec_cmd_t c);
		cmd = c;
		step(1);
		cmd = '0;
	endtask
	// stray strobes of other codes are skipped, not judged
	task automatic wait_err(input logic [9:0] code, input logic [1:0] cat);
		int n;
		n = 0;
		while (!(err_strobe.valid === 1'b1 && err_strobe.code === code) &&
			n < 40) begin
			step(1);
			n++;
		end
		if (n == 40) begin
			failures++;
			$display("CHECK FAILED %0t no strobe %h", $time, code);
			end_sim();
		end else begin
			chk({8'h0, err_strobe.cat}, {8'h0, cat}, "category");
			step(1);
		end
	endtask
	task automatic pop(input logic [9:0] code);
		chk(err_code, code, "queue head");
		err_read = 1'b1;
		step(1);
		err_read = 1'b0;
		step(3);
	endtask
	////////////////////////////////////////
	task automatic t_cmd();
		rcec_cmd_t c;
		logic [9:0] exp [10] = '{10'h065, 10'h065, 10'h066, 10'h066, 10'h067,
			10'h068, 10'h069, 10'h06a, 10'h06b, 10'h06c};
		for (int i = 0; i < 10; i++) begin
			c = base;
			case (i)
				0: c.hdr_ok = 1'b0;
				1: c.colon_space = 1'b1;
				2: c.num_ok = 1'b0;
				3: c.mask_val = 9'h100;
				4: c.bool_ok = 1'b0;
				5: c.arg_seen = 1'b0;
				6: c.range_bad = 1'b1;
				7: units = 2'h0;
				8: c.pass_match = 1'b0;
				default: ucal_exists = 1'b0;
			endcase
			send(c);
			wait_err(exp[i], 2'h0);
			units = 2'h1;
			ucal_exists = 1'b1;
		end
		send(base);
		chk({9'h0, cmd_exec}, 10'h001, "exec");
		chk({6'h0, cat_flags}, 10'h001, "flags");
		for (int i = 0; i < 10; i++) pop(exp[i]);
		chk({9'h0, err_empty}, 10'h001, "empty");
		cat_clear = 4'h1;
		step(1);
		cat_clear = 4'h0;
		step(1);
		chk({6'h0, cat_flags}, 10'h000, "cleared");
		$display("t_cmd done");
	endtask
	task automatic t_ovf();
		for (int i = 0; i < 12; i++) begin
			send('{valid: 1'b1, default: '0});
			wait_err(10'h065, 2'h0);
		end
		step(4);
		chk({6'h0, err_count}, 10'h00a, "full");
		for (int i = 0; i < 9; i++) pop(10'h065);
		pop(10'h12e);
		chk({9'h0, err_empty}, 10'h001, "empty");
		$display("t_ovf done");
	endtask
	task automatic t_qry();
		rcec_cmd_t q;
		q = '0;
		q.valid = 1'b1;
		q.is_query = 1'b1;
		q.hdr_ok = 1'b1;
		resp_busy = 1'b1;
		send(q);
		chk({9'h0, resp_flush}, 10'h001, "flush");
		wait_err(10'h0ca, 2'h1);
		resp_busy = 1'b0;
		q.hdr_ok = 1'b0;
		send(q);
		wait_err(10'h0c9, 2'h1);
		q.hdr_ok = 1'b1;
		q.len_access = 1'b1;
		units = 2'h0;
		send(q);
		wait_err(10'h0cb, 2'h1);
		units = 2'h1;
		pop(10'h0ca);
		pop(10'h0c9);
		pop(10'h0cb);
		$display("t_qry done");
	endtask
	task automatic t_inbuf();
		// occupancy output lags the counter by one register stage
		new_cmd = 1'b1;
		step(5);
		chk({7'h0, inbuf_used}, 10'h004, "used");
		chk({9'h0, cmd_drop}, 10'h001, "drop");
		new_cmd = 1'b0;
		wait_err(10'h12d, 2'h3);
		cmd_done = 1'b1;
		step(4);
		cmd_done = 1'b0;
		step(2);
		chk({7'h0, inbuf_used}, 10'h000, "freed");
		pop(10'h12d);
		$display("t_inbuf done");
	endtask
	task automatic t_ser();
		logic [9:0] exp [4] = '{10'h192, 10'h193, 10'h194, 10'h191};
		for (int k = 0; k < 4; k++) begin
			host_u.fault(k);
			wait_err(exp[k], 2'h2);
		end
		chk({9'h0, cat_flags[2]}, 10'h001, "device flag");
		for (int k = 0; k < 4; k++) pop(exp[k]);
		$display("t_ser done");
	endtask
	////////////////////////////////////////
	// main sequence: all inputs set at time zero, reset six cycles
	initial begin
		failures = 0;
		checked = 0;
		srst = 1'b1;
		cmd = '0;
		base = '{valid: 1'b1, hdr_ok: 1'b1, num_arg: 1'b1, num_ok: 1'b1,
			mask_arg: 1'b1, mask_val: 9'h0ff, bool_arg: 1'b1,
			bool_ok: 1'b1, need_arg: 1'b1, arg_seen: 1'b1,
			len_access: 1'b1, cal_change: 1'b1, pass_given: 1'b1,
			pass_match: 1'b1, sel_user: 1'b1, default: '0};
		units = 2'h1;
		ucal_exists = 1'b1;
		resp_busy = 1'b0;
		cmd_done = 1'b0;
		new_cmd = 1'b0;
		err_read = 1'b0;
		cat_clear = 4'h0;
		step(6);
		srst = 1'b0;
		step(1);
		t_cmd();
		t_ovf();
		t_qry();
		t_inbuf();
		t_ser();
		end_sim();
	end
endmodule
`default_nettype wire
